/* File: rtl/bhcs_regs.vh */
/*
 Holds the reset values, region indices and state codes of the local-bus
 hold and chip-select block.
 Assumes it is included by bare name from the block's design file.
*/
`ifndef BHCS_REGS_VH
`define BHCS_REGS_VH

// Region slots in the chip-select tables.
`define BHCS_IDX_UPPER 4'h0
`define BHCS_IDX_LOWER 4'h1
`define BHCS_IDX_GEN0 4'h2

// Upper region default after reset: memory 0FFC00H through 0FFFFFH.
`define BHCS_UPPER_START_RST 20'hFFC00
`define BHCS_UPPER_STOP_RST 20'hFFFFF

// Other regions come out of reset disabled with a null range.
`define BHCS_RANGE_RST 20'h00000

// Hold state machine codes.
`define BHCS_ST_OWN 2'h0
`define BHCS_ST_GRANT 2'h1
`define BHCS_ST_RETURN 2'h2

`endif

/* File: rtl/bhcs_top.v */
/*
 Local-bus hold arbitration, bus lock output and chip-select decode with
 generic selects that fall back to port one output bits.
 Assumes the bus-cycle engine outside gives a one-cycle start pulse with the
 cycle address and kind, a lock level and an instruction-boundary level, all
 synchronous to i_clk; range programming arrives on a plain config strobe.
*/
// Operation
// - Drive lock output active while the current bus cycle is locked.
// - Never grant hold while the lock output is active.
// - During reset, lock pin becomes an undriven, weakly-high input.
// - Release bus on hold only at instruction boundary outside locked code.
// - While grant acknowledge is high, bus and control outputs float.
// - Direction output follows whether the cycle transmits or receives.
// - Upper select hits memory or I/O in range; resets to top 1K memory.
// - Lower select hits memory only in range; inactive until programmed.
// - Each enabled generic select hits memory or I/O in its range.
// - A generic pin not enabled as select drives its port one bit.
// - Software can read back the actual level on port pins.
// - A cycle ends only on ready unless its region ignores ready.
`include "bhcs_regs.vh"

module bhcs_top #(
    parameter AW = 20
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_hold,
    input wire i_instr_boundary,
    input wire i_cyc_lock,
    input wire i_cyc_start,
    input wire [AW-1:0] i_cyc_addr,
    input wire i_cyc_io,
    input wire i_cyc_write,
    input wire i_ready,
    input wire i_lock_pin,
    input wire i_cfg_wr,
    input wire [3:0] i_cfg_idx,
    input wire [AW-1:0] i_cfg_start,
    input wire [AW-1:0] i_cfg_stop,
    input wire i_cfg_en,
    input wire i_cfg_io,
    input wire i_cfg_ign_rdy,
    input wire [7:0] i_port_data,
    input wire [7:0] i_gen_pin_level,
    output wire o_bus_grant_ack,
    output wire o_bus_oe,
    output wire o_lock_n_o,
    output wire o_lock_oe,
    output wire o_lock_pin_level,
    output wire o_buffer_direction_out,
    output wire o_cyc_busy,
    output wire o_cyc_done,
    output wire o_upper_region_select_n,
    output wire o_lower_region_select_n,
    output wire [7:0] o_generic_region_select_n,
    output wire [7:0] o_port_one_readback
);

    localparam NREG = 10;

    ////////////////////////////////////////////////////////////////////////
    // Region programming tables.
    reg [AW-1:0] start_q [0:NREG-1];
    reg [AW-1:0] stop_q [0:NREG-1];
    reg [NREG-1:0] en_q;
    reg [NREG-1:0] io_q;
    reg [NREG-1:0] ign_q;

    // Hold, cycle and output state.
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg cyc_q;
    reg cyc_ign_q;
    reg dir_q;
    reg lock_q;
    reg lock_in_q;
    reg [NREG-1:0] sel_n_q;
    reg [7:0] port_q;
    reg [7:0] readback_q;

    wire [NREG-1:0] hit;
    wire start_ok;
    wire done;
    integer k;

    ////////////////////////////////////////////////////////////////////////
    // Range compare for every region; lower is memory only.
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1)
        begin : g_hit
            wire kind_ok;
            if (g == 1)
            begin : g_mem
                assign kind_ok = ~i_cyc_io;
            end
            else
            begin : g_any
                assign kind_ok = (io_q[g] == i_cyc_io);
            end
            assign hit[g] = en_q[g] & kind_ok &
                            (i_cyc_addr >= start_q[g]) &
                            (i_cyc_addr <= stop_q[g]);
        end
    endgenerate

    // Cycles start only while the device owns the bus.
    assign start_ok = i_cyc_start & ~cyc_q & (st_q == `BHCS_ST_OWN);
    // A cycle finishes on ready or when its region ignores ready.
    assign done = cyc_q & (i_ready | cyc_ign_q);

    ////////////////////////////////////////////////////////////////////////
    // Programming writes; upper region defaults to the top 1K of memory.
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            for (k = 0; k < NREG; k = k + 1)
            begin
                start_q[k] <= `BHCS_RANGE_RST;
                stop_q[k] <= `BHCS_RANGE_RST;
            end
            start_q[0] <= `BHCS_UPPER_START_RST;
            stop_q[0] <= `BHCS_UPPER_STOP_RST;
            en_q <= 10'h001;
            io_q <= 10'h000;
            ign_q <= 10'h000;
        end
        else if (i_ce && i_cfg_wr && (i_cfg_idx < NREG))
        begin
            start_q[i_cfg_idx] <= i_cfg_start;
            stop_q[i_cfg_idx] <= i_cfg_stop;
            en_q[i_cfg_idx] <= i_cfg_en;
            io_q[i_cfg_idx] <= i_cfg_io;
            ign_q[i_cfg_idx] <= i_cfg_ign_rdy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold state machine: grant only between unlocked instructions.
    always @*
    begin
        st_d = st_q;
        case (st_q)
            `BHCS_ST_OWN:
            begin
                if (i_hold && !cyc_q && !lock_q && !i_cyc_lock &&
                    i_instr_boundary && !i_cyc_start)
                    st_d = `BHCS_ST_GRANT;
            end
            `BHCS_ST_GRANT:
            begin
                if (!i_hold)
                    st_d = `BHCS_ST_RETURN;
            end
            `BHCS_ST_RETURN:
            begin
                st_d = `BHCS_ST_OWN;
            end
            default:
            begin
                st_d = `BHCS_ST_OWN;
            end
        endcase
    end

    // State, cycle tracking, lock and direction registers.
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            st_q <= `BHCS_ST_OWN;
            cyc_q <= 1'b0;
            cyc_ign_q <= 1'b0;
            dir_q <= 1'b0;
            lock_q <= 1'b0;
            lock_in_q <= 1'b1;
        end
        else if (i_ce)
        begin
            st_q <= st_d;
            lock_in_q <= i_lock_pin;
            // Lock follows the locked sequence, not while granted away.
            lock_q <= i_cyc_lock & (st_d == `BHCS_ST_OWN);
            if (start_ok)
            begin
                cyc_q <= 1'b1;
                cyc_ign_q <= |(hit & ign_q);
                dir_q <= i_cyc_write;
            end
            else if (done)
            begin
                cyc_q <= 1'b0;
                cyc_ign_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select outputs held high in reset and grant; port bits high in reset only.
    always @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            sel_n_q <= 10'h3FF;
            port_q <= 8'hFF;
            readback_q <= 8'h00;
        end
        else if (i_ce)
        begin
            port_q <= i_port_data;
            readback_q <= i_gen_pin_level;
            if (st_d != `BHCS_ST_OWN)
                sel_n_q <= 10'h3FF;
            else if (start_ok)
                sel_n_q <= ~hit;
            else if (done)
                sel_n_q <= 10'h3FF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: lock floats in reset and grant so the pull-up holds it.
    assign o_lock_oe = i_rstn & (st_q == `BHCS_ST_OWN);
    assign o_lock_n_o = ~lock_q;
    assign o_lock_pin_level = lock_in_q;
    assign o_bus_grant_ack = (st_q == `BHCS_ST_GRANT);
    // Bus and control drive only after acknowledge has dropped.
    assign o_bus_oe = i_rstn & (st_q == `BHCS_ST_OWN);
    assign o_buffer_direction_out = dir_q;
    assign o_cyc_busy = cyc_q;
    assign o_cyc_done = done;
    assign o_upper_region_select_n = sel_n_q[0];
    assign o_lower_region_select_n = sel_n_q[1];

    // Generic pins carry a select when enabled, else the port bit.
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_pin
            assign o_generic_region_select_n[g] = en_q[g+2] ?
                sel_n_q[g+2] : port_q[g];
        end
    endgenerate
    assign o_port_one_readback = readback_q;

endmodule

/* File: tb/bhcs_top_asserts.sv */
/*
 Checks of the hold and chip-select block.
 Assumes one clock and a synchronous active-low reset.
*/
module bhcs_top_asserts (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cyc_lock,
    input wire logic i_instr_boundary,
    input wire logic o_bus_grant_ack,
    input wire logic o_bus_oe,
    input wire logic o_lock_n_o,
    input wire logic o_lock_oe,
    input wire logic o_cyc_busy,
    input wire logic o_cyc_done,
    input wire logic o_upper_region_select_n,
    input wire logic o_lower_region_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks share the clock; all but the reset check are off in reset.
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_lk; o_bus_oe && i_cyc_lock |=> !o_lock_n_o; endproperty
    a_lk: assert property (p_lk) else $error("lock");
    property p_ng; !o_lock_n_o && !o_bus_grant_ack |=> !o_bus_grant_ack;
    endproperty
    a_ng: assert property (p_ng) else $error("grant");
    property p_rs; disable iff (1'b0) !i_rstn |-> !o_lock_oe && !o_bus_oe;
    endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_bd; $rose(o_bus_grant_ack) |->
        $past(i_instr_boundary) && !$past(i_cyc_lock); endproperty
    a_bd: assert property (p_bd) else $error("boundary");
    property p_fl; o_bus_grant_ack |-> !o_bus_oe && !o_lock_oe; endproperty
    a_fl: assert property (p_fl) else $error("float");
    property p_cs; o_bus_grant_ack |->
        o_upper_region_select_n && o_lower_region_select_n; endproperty
    a_cs: assert property (p_cs) else $error("select");
    property p_rt; $fell(o_bus_grant_ack) |-> !o_bus_oe ##1 o_bus_oe;
    endproperty
    a_rt: assert property (p_rt) else $error("return");
    property p_by; o_cyc_busy && !o_cyc_done |=> o_cyc_busy; endproperty
    a_by: assert property (p_by) else $error("busy");
endmodule
////////////////////////////////////////
bind bhcs_top bhcs_top_asserts i_chk (.i_clk, .i_rstn, .i_cyc_lock,
    .i_instr_boundary, .o_bus_grant_ack, .o_bus_oe, .o_lock_n_o, .o_lock_oe,
    .o_cyc_busy, .o_cyc_done, .o_upper_region_select_n,
    .o_lower_region_select_n);

/* File: tb/bhcs_master.sv */
/*
 Outside bus master asking for the local bus.
 Assumes a pull-up on the lock pin.
*/
module bhcs_master (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_ack,
    input wire logic i_lock_oe,
    input wire logic i_lock_n,
    output logic o_hold,
    output wire logic o_lock_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    // The pull-up wins when the device lets go; we never pull low.
    assign o_lock_pin = i_lock_oe ? i_lock_n : 1'b1;
    initial o_hold = 1'b0;
    // Request on go, hand the bus back after nine granted cycles.
    always @(posedge i_clk)
    begin
        n <= i_go ? 0 : n + (o_hold & i_ack);
        o_hold <= i_go | (o_hold & (n < 8));
    end
endmodule

/* File: tb/bhcs_top_tb.sv */
/*
 Self-checking bench of the hold and chip-select block.
 Assumes the master model and the checker.
*/
module bhcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rstn = 0, go = 0, i_ready = 0, i_hold, i_lock_pin;
    logic i_instr_boundary = 1, i_cyc_lock = 0, i_cyc_start = 0;
    logic i_cyc_io = 0, i_cyc_write = 0, i_cfg_wr = 0, i_cfg_io = 0;
    logic i_cfg_ign_rdy = 0, ack, oe, lk_n, lk_oe, lk_lv, done, up, lo, dir;
    logic i_cfg_en = 1;
    logic [19:0] i_cyc_addr = 0, i_cfg_start = 0, i_cfg_stop = 0, a;
    logic [7:0] pd = 0, lvl = 0, en = 0, gen, rb;
    logic [3:0] i_cfg_idx = 0;
    logic [10:0] exp_q[$];
    int n_mismatch = 0, checks_done = 0;
    bhcs_top i_dut (.i_clk, .i_rstn, .i_ce(1'b1), .i_hold, .i_instr_boundary,
        .i_cyc_lock, .i_cyc_start, .i_cyc_addr, .i_cyc_io, .i_cyc_write,
        .i_ready, .i_lock_pin, .i_cfg_wr, .i_cfg_idx, .i_cfg_start,
        .i_cfg_stop, .i_cfg_en, .i_cfg_io, .i_cfg_ign_rdy,
        .i_port_data(pd), .i_gen_pin_level(lvl), .o_bus_grant_ack(ack),
        .o_bus_oe(oe), .o_lock_n_o(lk_n), .o_lock_oe(lk_oe),
        .o_lock_pin_level(lk_lv), .o_buffer_direction_out(dir),
        .o_cyc_busy(), .o_cyc_done(done), .o_upper_region_select_n(up),
        .o_lower_region_select_n(lo), .o_generic_region_select_n(gen),
        .o_port_one_readback(rb));
    bhcs_master i_mst (.i_clk, .i_go(go), .i_ack(ack), .i_lock_oe(lk_oe),
        .i_lock_n(lk_n), .o_hold(i_hold), .o_lock_pin(i_lock_pin));
    ////////////////////////////////////////
    // Counts a compare and reports a difference.
    task chk(input string s, input logic [10:0] v, e);
        begin
            checks_done++;
            if (v !== e)
            begin
                n_mismatch++;
                $display("ERROR %s exp %h seen %h", s, e, v);
            end
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Programs one region with a one-cycle strobe.
    task cfg(input logic [3:0] x, input logic [19:0] s, t, input logic i, g);
        begin
            {i_cfg_idx, i_cfg_start, i_cfg_stop, i_cfg_io} = {x, s, t, i};
            {i_cfg_ign_rdy, i_cfg_wr} = {g, 1'b1};
            @(posedge i_clk);
            #1 i_cfg_wr = 0;
        end
    endtask
    // Runs one bus cycle and notes the selects it should show.
    task cyc(input logic [19:0] ad, input logic io, input logic [9:0] e);
        logic w;
        begin
            w = 1'($urandom);
            exp_q.push_back({e, w});
            {i_cyc_addr, i_cyc_io, i_cyc_write} = {ad, io, w};
            i_cyc_start = 1;
            @(posedge i_clk);
            #1 i_cyc_start = 0;
            @(posedge i_clk iff done === 1'b1);
            #1;
        end
    endtask
    ////////////////////////////////////////
    // Clock, random ready, and the result monitor.
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) i_ready <= #1 1'($urandom);
    // Looks mid-cycle, where selects and done have settled.
    always @(negedge i_clk)
        if (done === 1'b1)
            chk("sel", {up, lo, gen, dir}, exp_q.pop_front());
    // Cuts a hang short.
    initial
    begin
        #20000 n_mismatch++;
        stop_test;
    end
    // Main sequence.
    initial
    begin
        void'($urandom(32'hdc91));
        pd = 8'($urandom);
        lvl = 8'($urandom);
        repeat (5) @(posedge i_clk);
        #1 i_rstn = 1;
        @(posedge i_clk);
        #1 chk("lockpin", lk_lv, 1);
        chk("readback", rb, lvl);
        cyc(20'hFFC00 | 20'($urandom % 1024), 0, {2'b01, pd});
        cyc(20'hFFFFF, 1, {2'b11, pd});
        cyc(20'hFFBFF, 0, {2'b11, pd});
        cfg(1, 0, 20'h0FFFF, 0, 0);
        cyc(20'h0ABCD, 0, {2'b10, pd});
        cyc(20'h0ABCD, 1, {2'b11, pd});
        for (int k = 0; k < 8; k++)
        begin
            a = 20'h20000 + 20'(k * 4096);
            cfg(4'(k + 2), a, a + 20'hFFF, k[0], k == 7);
            en[k] = 1;
            cyc(a + 20'($urandom % 4096), k[0],
                {2'b11, ~en & pd | en & ~(8'h01 << k)});
            cyc(a, !k[0], {2'b11, ~en & pd | en});
        end
        // A generic region switched off gives its pin back to the port.
        pd = pd | 8'h08;
        i_cfg_en = 0;
        cfg(4'h5, 20'h23000, 20'h23FFF, 1, 0);
        i_cfg_en = 1;
        en[3] = 0;
        cyc(20'h23010, 1, {2'b11, ~en & pd | en});
        go = 1;
        for (int i = 0; i < 3; i++)
        begin
            {i_cyc_lock, i_instr_boundary} = {i == 0, i != 1};
            @(posedge i_clk);
            #1 go = 0;
            repeat (3) @(posedge i_clk);
            #1 chk("ack", ack, i == 2);
            chk("lock", lk_n, i != 0);
        end
        repeat (12) @(posedge i_clk);
        #1 chk("own", {ack, oe}, 1);
        // Reset in mid-run: pins float and regions return to defaults.
        i_rstn = 0;
        @(posedge i_clk);
        #1 chk("rst", {up, lo, lk_oe, oe}, 4'hC);
        @(posedge i_clk);
        #1 i_rstn = 1;
        en = 0;
        cyc(20'h0ABCD, 0, {2'b11, pd});
        cyc(20'hFFC00, 0, {2'b01, pd});
        stop_test;
    end
endmodule
